// ==== design/gain_switch_pkg.sv ====
// Purpose: shared constants for the servo gain switching block
// Assumes: 25 MHz system clock, Avalon-MM word-addressed register slave
// Notes: offsets are byte addresses; the bus carries word index = offset / 4
package gain_switch_pkg;
   // ---------------------------------------------------------------
   // clock and timing
   // ---------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 40;
   localparam int MS_NS = 1000000;
   localparam int CYCLES_PER_MS = (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // ---------------------------------------------------------------
   // register byte offsets
   // ---------------------------------------------------------------
   localparam logic [6:0] OFS_INERTIA_BASE = 7'h00;
   localparam logic [6:0] OFS_POS_BASE = 7'h04;
   localparam logic [6:0] OFS_SPEED_BASE = 7'h08;
   localparam logic [6:0] OFS_INTEG_BASE = 7'h0C;
   localparam logic [6:0] OFS_TRIGGER = 7'h10;
   localparam logic [6:0] OFS_THRESHOLD = 7'h14;
   localparam logic [6:0] OFS_TIME_CONST = 7'h18;
   localparam logic [6:0] OFS_INERTIA_ALT = 7'h1C;
   localparam logic [6:0] OFS_POS_SCALE = 7'h20;
   localparam logic [6:0] OFS_SPEED_SCALE = 7'h24;
   localparam logic [6:0] OFS_INTEG_SCALE = 7'h28;
   localparam logic [6:0] OFS_TUNING_MODE = 7'h2C;
   localparam logic [6:0] OFS_STATUS = 7'h30;
   localparam logic [6:0] OFS_ACT_INERTIA = 7'h34;
   localparam logic [6:0] OFS_ACT_POS = 7'h38;
   localparam logic [6:0] OFS_ACT_SPEED = 7'h3C;
   localparam logic [6:0] OFS_ACT_INTEG = 7'h40;

   // ---------------------------------------------------------------
   // reset values
   // ---------------------------------------------------------------
   localparam logic [15:0] RST_INERTIA = 16'h0046;
   localparam logic [15:0] RST_POS_BASE = 16'h002D;
   localparam logic [15:0] RST_SPEED_BASE = 16'h00B7;
   localparam logic [15:0] RST_INTEG_BASE = 16'h0022;
   localparam logic [3:0] RST_TRIGGER = 4'h0;
   localparam logic [31:0] RST_THRESHOLD = 32'h0000000A;
   localparam logic [15:0] RST_TIME_CONST = 16'h0001;
   localparam logic [15:0] RST_SCALE = 16'h0064;
   localparam logic [1:0] RST_TUNING_MODE = 2'h2;

   // ---------------------------------------------------------------
   // setting bounds
   // ---------------------------------------------------------------
   localparam logic [15:0] INERTIA_MAX = 16'h04B0;
   localparam logic [15:0] POS_MIN = 16'h0004;
   localparam logic [15:0] POS_MAX = 16'h0400;
   localparam logic [15:0] SPEED_MIN = 16'h0028;
   localparam logic [15:0] SPEED_MAX = 16'h2328;
   localparam logic [15:0] INTEG_MIN = 16'h0001;
   localparam logic [15:0] INTEG_MAX = 16'h03E8;
   localparam logic [15:0] TIME_CONST_MAX = 16'h03E8;
   localparam logic [15:0] SCALE_MIN = 16'h000A;
   localparam logic [15:0] SCALE_MAX = 16'h01F4;
   localparam logic [31:0] THRESHOLD_MAX = 32'h003D0900;
   localparam logic [3:0] TRIGGER_MAX = 4'h8;
   localparam logic [1:0] MODE_MANUAL_MAX = 2'h1;
   localparam logic [1:0] MODE_COMPENSATED = 2'h1;
   localparam logic [31:0] PERCENT = 32'h00000064;

   // ---------------------------------------------------------------
   // trigger condition codes
   // ---------------------------------------------------------------
   localparam logic [3:0] TRIG_OFF = 4'h0;
   localparam logic [3:0] TRIG_IN_ON = 4'h1;
   localparam logic [3:0] TRIG_FREQ_GE = 4'h2;
   localparam logic [3:0] TRIG_ERR_GE = 4'h3;
   localparam logic [3:0] TRIG_SPEED_GE = 4'h4;
   localparam logic [3:0] TRIG_IN_OFF = 4'h5;
   localparam logic [3:0] TRIG_FREQ_LT = 4'h6;
   localparam logic [3:0] TRIG_ERR_LT = 4'h7;
   localparam logic [3:0] TRIG_SPEED_LT = 4'h8;
endpackage

// ==== design/gain_ramp.sv ====
// Purpose: smooths one loop quantity toward its target value
// Assumes: tick is a one-cycle pulse once per millisecond
// Notes: lag of about 2^shift ms; bypass jumps straight to the target
`timescale 1ns/100ps
module gain_ramp #(
   parameter logic [15:0] INIT = 16'h0000
) (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic tick,
   input wire logic bypass,
   input wire logic [3:0] shift,
   input wire logic [15:0] target,
   output logic [15:0] value_q
);
   logic [15:0] gap;
   logic [15:0] step;

   assign gap = (target >= value_q) ? (target - value_q) : (value_q - target);
   // step never drops to zero, so the output always reaches the target
   assign step = ((gap >> shift) == 16'h0000) ? 16'h0001 : (gap >> shift);

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         value_q <= INIT;
      end else if (bypass) begin
         value_q <= target;
      end else if (tick && gap != 16'h0000) begin
         value_q <= (target > value_q) ? value_q + step : value_q - step;
      end
   end

   a_ramp_toward: assert property (@(posedge clk_sys) disable iff (!rst_n)
      tick && !bypass && value_q < target |=> value_q > $past(value_q) && value_q <= $past(target))
      else $error("ramp did not advance toward target");
endmodule

// ==== design/servo_gain_switch.sv ====
// Purpose: gain scheduling for the servo loops with Avalon-MM register access
// Assumes: measurement inputs come from logic on clk_sys; switch input is a pin
// Notes: active gains reach their targets through a per-millisecond smoother
`timescale 1ns/100ps
// How it works
// - switching happens only in a manual tuning mode, never in automatic modes.
// - trigger code is the low digit of the option; legal 0 to 8, reset 0.
// - code 0 never switches; 1 switches on input high; 5 on input low.
// - code 2 switches when command frequency reaches threshold; 6 when below.
// - code 3 switches when pulse error reaches threshold; 7 when below.
// - code 4 switches when motor speed reaches threshold; 8 when below.
// - threshold takes 0 to 4000000, reset 10, unit set by the trigger code.
// - while switched, the alternate inertia ratio replaces the base one.
// - while switched, position, speed and integral gains scale by their percentages.
// - transitions between gain sets are smoothed by the switch time constant.
// - base gains are clamped to their legal ranges on write.
// - tuning modes 0 and 1 are manual; mode 1 also enables compensation.
module servo_gain_switch
   import gain_switch_pkg::*;
#(
   parameter int MS_CYCLES = CYCLES_PER_MS
) (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic [4:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic gain_switch_in,
   input wire logic [31:0] cmd_freq_kpps,
   input wire logic [31:0] pulse_error,
   input wire logic [31:0] motor_speed_rpm,
   output logic [15:0] inertia_ratio_out,
   output logic [15:0] position_gain_out,
   output logic [15:0] speed_gain_out,
   output logic [15:0] speed_integral_out,
   output logic switched_out,
   output logic compensator_en
);
   // ---------------------------------------------------------------
   // registers and state
   // ---------------------------------------------------------------
   logic [15:0] inertia_ratio_base_q;
   logic [15:0] position_loop_gain_base_q;
   logic [15:0] speed_loop_gain_base_q;
   logic [15:0] speed_integral_base_q;
   logic [3:0] switch_trigger_select_q;
   logic [31:0] switch_threshold_q;
   logic [15:0] switch_time_constant_q;
   logic [15:0] inertia_ratio_alt_q;
   logic [15:0] position_gain_scale_q;
   logic [15:0] speed_gain_scale_q;
   logic [15:0] integral_scale_q;
   logic [1:0] tuning_mode_select_q;
   logic wait_q;
   logic [31:0] rdata_q;
   logic pin_meta_q;
   logic pin_sync_q;
   logic switched_q;
   logic comp_q;
   logic [15:0] ms_cnt_q;
   logic ms_tick_q;
   logic [6:0] byte_addr;
   logic wr_en;
   logic manual;
   logic cond;
   logic [3:0] ramp_shift;
   logic bypass;
   logic [15:0] tgt_inertia;
   logic [15:0] tgt_pos;
   logic [15:0] tgt_speed;
   logic [15:0] tgt_integ;
   logic [15:0] scaled_pos;
   logic [15:0] scaled_speed;
   logic [15:0] scaled_integ;

   function automatic logic [15:0] clamp16(input logic [31:0] v, input logic [15:0] lo,
                                           input logic [15:0] hi);
      if (v < {16'h0000, lo}) begin
         return lo;
      end else if (v > {16'h0000, hi}) begin
         return hi;
      end
      return v[15:0];
   endfunction

   function automatic logic [15:0] scale(input logic [15:0] base, input logic [15:0] pct);
      logic [31:0] prod;
      prod = ({16'h0000, base} * {16'h0000, pct}) / PERCENT;
      return prod[15:0];
   endfunction

   // ---------------------------------------------------------------
   // avalon slave: one wait cycle, answer in the second cycle
   // ---------------------------------------------------------------
   assign byte_addr = {avs_address, 2'b00};
   assign wr_en = avs_write && !wait_q;

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         wait_q <= 1'b1;
      end else begin
         wait_q <= !((avs_read || avs_write) && wait_q);
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         rdata_q <= 32'h00000000;
      end else if (avs_read && wait_q) begin
         unique case (byte_addr)
            OFS_INERTIA_BASE: rdata_q <= {16'h0000, inertia_ratio_base_q};
            OFS_POS_BASE: rdata_q <= {16'h0000, position_loop_gain_base_q};
            OFS_SPEED_BASE: rdata_q <= {16'h0000, speed_loop_gain_base_q};
            OFS_INTEG_BASE: rdata_q <= {16'h0000, speed_integral_base_q};
            OFS_TRIGGER: rdata_q <= {28'h0000000, switch_trigger_select_q};
            OFS_THRESHOLD: rdata_q <= switch_threshold_q;
            OFS_TIME_CONST: rdata_q <= {16'h0000, switch_time_constant_q};
            OFS_INERTIA_ALT: rdata_q <= {16'h0000, inertia_ratio_alt_q};
            OFS_POS_SCALE: rdata_q <= {16'h0000, position_gain_scale_q};
            OFS_SPEED_SCALE: rdata_q <= {16'h0000, speed_gain_scale_q};
            OFS_INTEG_SCALE: rdata_q <= {16'h0000, integral_scale_q};
            OFS_TUNING_MODE: rdata_q <= {30'h0, tuning_mode_select_q};
            OFS_STATUS: rdata_q <= {29'h0, comp_q, cond, switched_q};
            OFS_ACT_INERTIA: rdata_q <= {16'h0000, inertia_ratio_out};
            OFS_ACT_POS: rdata_q <= {16'h0000, position_gain_out};
            OFS_ACT_SPEED: rdata_q <= {16'h0000, speed_gain_out};
            OFS_ACT_INTEG: rdata_q <= {16'h0000, speed_integral_out};
            default: rdata_q <= 32'h00000000;
         endcase
      end
   end

   assign avs_readdata = rdata_q;
   assign avs_waitrequest = wait_q;

   // ---------------------------------------------------------------
   // parameter registers: out-of-range writes are clamped or dropped; tuning mode keeps only bits 1:0
   // ---------------------------------------------------------------
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         inertia_ratio_base_q <= RST_INERTIA;
         position_loop_gain_base_q <= RST_POS_BASE;
         speed_loop_gain_base_q <= RST_SPEED_BASE;
         speed_integral_base_q <= RST_INTEG_BASE;
         switch_trigger_select_q <= RST_TRIGGER;
         switch_threshold_q <= RST_THRESHOLD;
         switch_time_constant_q <= RST_TIME_CONST;
         inertia_ratio_alt_q <= RST_INERTIA;
         position_gain_scale_q <= RST_SCALE;
         speed_gain_scale_q <= RST_SCALE;
         integral_scale_q <= RST_SCALE;
         tuning_mode_select_q <= RST_TUNING_MODE;
      end else if (wr_en) begin
         unique case (byte_addr)
            OFS_INERTIA_BASE:
               inertia_ratio_base_q <= clamp16(avs_writedata, 16'h0000, INERTIA_MAX);
            OFS_POS_BASE:
               position_loop_gain_base_q <= clamp16(avs_writedata, POS_MIN, POS_MAX);
            OFS_SPEED_BASE:
               speed_loop_gain_base_q <= clamp16(avs_writedata, SPEED_MIN, SPEED_MAX);
            OFS_INTEG_BASE:
               speed_integral_base_q <= clamp16(avs_writedata, INTEG_MIN, INTEG_MAX);
            OFS_TRIGGER: begin
               // an illegal condition code would leave the trigger undefined
               if (avs_writedata[31:4] == 28'h0000000 && avs_writedata[3:0] <= TRIGGER_MAX) begin
                  switch_trigger_select_q <= avs_writedata[3:0];
               end
            end
            OFS_THRESHOLD:
               switch_threshold_q <= (avs_writedata > THRESHOLD_MAX) ? THRESHOLD_MAX
                                                                    : avs_writedata;
            OFS_TIME_CONST:
               switch_time_constant_q <= clamp16(avs_writedata, 16'h0000, TIME_CONST_MAX);
            OFS_INERTIA_ALT:
               inertia_ratio_alt_q <= clamp16(avs_writedata, 16'h0000, INERTIA_MAX);
            OFS_POS_SCALE:
               position_gain_scale_q <= clamp16(avs_writedata, SCALE_MIN, SCALE_MAX);
            OFS_SPEED_SCALE:
               speed_gain_scale_q <= clamp16(avs_writedata, SCALE_MIN, SCALE_MAX);
            OFS_INTEG_SCALE:
               integral_scale_q <= clamp16(avs_writedata, SCALE_MIN, SCALE_MAX);
            OFS_TUNING_MODE:
               tuning_mode_select_q <= avs_writedata[1:0];
            default: begin
            end
         endcase
      end
   end

   // ---------------------------------------------------------------
   // trigger evaluation
   // ---------------------------------------------------------------
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         pin_meta_q <= 1'b0;
         pin_sync_q <= 1'b0;
      end else begin
         pin_meta_q <= gain_switch_in;
         pin_sync_q <= pin_meta_q;
      end
   end

   assign manual = tuning_mode_select_q <= MODE_MANUAL_MAX;

   always_comb begin
      unique case (switch_trigger_select_q)
         TRIG_IN_ON: cond = pin_sync_q;
         TRIG_IN_OFF: cond = !pin_sync_q;
         TRIG_FREQ_GE: cond = cmd_freq_kpps >= switch_threshold_q;
         TRIG_FREQ_LT: cond = cmd_freq_kpps < switch_threshold_q;
         TRIG_ERR_GE: cond = pulse_error >= switch_threshold_q;
         TRIG_ERR_LT: cond = pulse_error < switch_threshold_q;
         TRIG_SPEED_GE: cond = motor_speed_rpm >= switch_threshold_q;
         TRIG_SPEED_LT: cond = motor_speed_rpm < switch_threshold_q;
         default: cond = 1'b0;
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         switched_q <= 1'b0;
         comp_q <= 1'b0;
      end else begin
         switched_q <= manual && cond;
         comp_q <= tuning_mode_select_q == MODE_COMPENSATED;
      end
   end

   assign switched_out = switched_q;
   assign compensator_en = comp_q;

   // ---------------------------------------------------------------
   // smoothing: millisecond tick and four ramps
   // ---------------------------------------------------------------
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         ms_cnt_q <= 16'h0000;
         ms_tick_q <= 1'b0;
      end else begin
         ms_tick_q <= ms_cnt_q == 16'(MS_CYCLES - 1);
         ms_cnt_q <= (ms_cnt_q == 16'(MS_CYCLES - 1)) ? 16'h0000 : ms_cnt_q + 16'h0001;
      end
   end

   // lag is a power of two near the set constant; trades accuracy for no divider
   always_comb begin
      ramp_shift = 4'h0;
      for (int i = 1; i < 16; i++) begin
         if (switch_time_constant_q[i]) begin
            ramp_shift = 4'(i);
         end
      end
   end

   assign bypass = switch_time_constant_q == 16'h0000;
   assign scaled_pos = scale(position_loop_gain_base_q, position_gain_scale_q);
   assign scaled_speed = scale(speed_loop_gain_base_q, speed_gain_scale_q);
   assign scaled_integ = scale(speed_integral_base_q, integral_scale_q);
   assign tgt_inertia = switched_q ? inertia_ratio_alt_q : inertia_ratio_base_q;
   assign tgt_pos = switched_q ? scaled_pos : position_loop_gain_base_q;
   assign tgt_speed = switched_q ? scaled_speed : speed_loop_gain_base_q;
   assign tgt_integ = switched_q ? scaled_integ : speed_integral_base_q;

   gain_ramp #(.INIT(RST_INERTIA)) u_ramp_inertia (.clk_sys(clk_sys), .rst_n(rst_n),
      .tick(ms_tick_q), .bypass(bypass), .shift(ramp_shift), .target(tgt_inertia),
      .value_q(inertia_ratio_out));
   gain_ramp #(.INIT(RST_POS_BASE)) u_ramp_pos (.clk_sys(clk_sys), .rst_n(rst_n),
      .tick(ms_tick_q), .bypass(bypass), .shift(ramp_shift), .target(tgt_pos),
      .value_q(position_gain_out));
   gain_ramp #(.INIT(RST_SPEED_BASE)) u_ramp_speed (.clk_sys(clk_sys), .rst_n(rst_n),
      .tick(ms_tick_q), .bypass(bypass), .shift(ramp_shift), .target(tgt_speed),
      .value_q(speed_gain_out));
   gain_ramp #(.INIT(RST_INTEG_BASE)) u_ramp_integ (.clk_sys(clk_sys), .rst_n(rst_n),
      .tick(ms_tick_q), .bypass(bypass), .shift(ramp_shift), .target(tgt_integ),
      .value_q(speed_integral_out));

   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);

   a_bus_answer: assert property ((avs_read || avs_write) && wait_q |=> !wait_q ##1 wait_q)
      else $error("waitrequest sequence wrong");
   a_auto_inhibit: assert property (tuning_mode_select_q > MODE_MANUAL_MAX
      |=> !switched_q)
      else $error("switched in automatic tuning mode");
   a_trigger_legal: assert property (switch_trigger_select_q <= TRIGGER_MAX)
      else $error("trigger code out of range");
   a_input_level: assert property (manual && switch_trigger_select_q == TRIG_IN_OFF
      && !pin_sync_q |=> switched_q)
      else $error("code 5 failed to switch on low input");
   a_code_zero: assert property (switch_trigger_select_q == TRIG_OFF |=> !switched_q)
      else $error("code 0 switched");
   a_freq_ge: assert property (manual && switch_trigger_select_q == TRIG_FREQ_GE
      && cmd_freq_kpps >= switch_threshold_q |=> switched_q)
      else $error("frequency compare failed");
   a_error_lt: assert property (manual && switch_trigger_select_q == TRIG_ERR_LT
      && pulse_error < switch_threshold_q |=> switched_q)
      else $error("pulse error compare failed");
   a_speed_ge: assert property (switch_trigger_select_q == TRIG_SPEED_GE
      && motor_speed_rpm < switch_threshold_q |=> !switched_q)
      else $error("speed compare switched below threshold");
   a_thresh_range: assert property (switch_threshold_q <= THRESHOLD_MAX)
      else $error("threshold above range");
   a_alt_inertia: assert property (switched_q && bypass |=>
      inertia_ratio_out == $past(inertia_ratio_alt_q))
      else $error("alternate inertia not applied");
   a_scaled_gain: assert property (switched_q && bypass |=>
      position_gain_out == 16'((32'($past(position_loop_gain_base_q))
      * 32'($past(position_gain_scale_q))) / PERCENT))
      else $error("scaled position gain wrong");
   a_base_bounds: assert property (speed_loop_gain_base_q >= SPEED_MIN
      && speed_loop_gain_base_q <= SPEED_MAX && position_loop_gain_base_q <= POS_MAX)
      else $error("base gain out of bounds");
   a_compensator: assert property (comp_q
      |-> $past(tuning_mode_select_q) == MODE_COMPENSATED)
      else $error("compensator enable wrong");
   a_return_base: assert property (!switched_q && bypass |=>
      speed_gain_out == $past(speed_loop_gain_base_q))
      else $error("base gain not restored");

   c_switch_on: cover property (!switched_q ##1 switched_q);
   c_switch_off: cover property (switched_q ##1 !switched_q);
   c_input_low: cover property (switch_trigger_select_q == TRIG_IN_OFF && switched_q);
   c_ramp_step: cover property (ms_tick_q && switched_q && !bypass);
endmodule

// ==== testbench/motion_host.sv ====
// Purpose: host motion controller model feeding the switch pin and measurements
// Assumes: code names the selected condition, hit asks for it to hold
// Notes: unselected measurements carry fresh noise every cycle
`timescale 1ns/100ps
module motion_host (
   input wire logic clk_sys,
   input wire logic [3:0] code,
   input wire logic hit,
   input wire logic [31:0] thr,
   output logic gain_switch_in = 1'b0,
   output logic [31:0] cmd_freq_kpps = 32'h0,
   output logic [31:0] pulse_error = 32'h0,
   output logic [31:0] motor_speed_rpm = 32'h0
);
   // sits on the threshold or one below it, the boundary a slip would miss
   logic [31:0] lvl;
   assign lvl = (hit ^ (code > 4'h4)) ? thr : thr - 32'h1;
   always @(posedge clk_sys) begin
      gain_switch_in <= hit ^ (code > 4'h4);
      cmd_freq_kpps <= (code[1:0] == 2'h2) ? lvl : $urandom;
      pulse_error <= (code[1:0] == 2'h3) ? lvl : $urandom;
      motor_speed_rpm <= (code[1:0] == 2'h0 && code != 4'h0) ? lvl : $urandom;
   end
endmodule

// ==== testbench/servo_gain_switch_tb_top.sv ====
// Purpose: self-checking bench for servo_gain_switch
// Assumes: MS_CYCLES shortened to 8 so smoothing settles fast
// Notes: every result comes back as a register read, checked off a queue
`timescale 1ns/100ps
module servo_gain_switch_tb_top
   import gain_switch_pkg::*;
();
   logic clk_sys = 1'b0, rst_n = 1'b0, avs_read = 1'b0, avs_write = 1'b0, hit = 1'b0;
   logic [4:0] avs_address = 5'h0;
   logic [3:0] code = 4'h0;
   logic [31:0] avs_writedata = 32'h0, thr = 32'hA, avs_readdata, pb, ps, sb, ss, ib, is2;
   logic avs_waitrequest, switched_out, compensator_en, gain_switch_in;
   logic [15:0] inertia_ratio_out, position_gain_out, speed_gain_out, speed_integral_out;
   logic [31:0] cmd_freq_kpps, pulse_error, motor_speed_rpm, exp_q[$], exp_seen;
   logic [6:0] adr_q[$], ofs_seen;
   logic [31:0] rst_tab [12] = '{32'h46, 32'h2D, 32'hB7, 32'h22, 32'h0, 32'hA, 32'h1,
      32'h46, 32'h64, 32'h64, 32'h64, 32'h2};
   int errors = 0, n_checks = 0, cyc = 0;
   always #20 clk_sys = ~clk_sys;
   servo_gain_switch #(.MS_CYCLES(8)) dut (.clk_sys, .rst_n, .avs_address, .avs_read,
      .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest, .gain_switch_in,
      .cmd_freq_kpps, .pulse_error, .motor_speed_rpm, .inertia_ratio_out,
      .position_gain_out, .speed_gain_out, .speed_integral_out, .switched_out,
      .compensator_en);
   motion_host host (.clk_sys, .code, .hit, .thr, .gain_switch_in, .cmd_freq_kpps,
      .pulse_error, .motor_speed_rpm);
   // ---------------------------------------------------------------
   // bus tasks and checking
   // ---------------------------------------------------------------
   task automatic check(input logic [6:0] ofs, input logic [31:0] exp, input logic [31:0] seen);
      n_checks++;
      if (seen !== exp) begin
         errors++;
         $display("BAD reg %h expected %h seen %h", ofs, exp, seen);
      end
   endtask
   task automatic tally_and_finish();
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   // one idle edge after release so the next request never re-drives in the same step
   task automatic wr(input logic [6:0] ofs, input logic [31:0] d);
      avs_address <= ofs[6:2];
      avs_writedata <= d;
      avs_write <= 1'b1;
      @(posedge clk_sys);
      while (avs_waitrequest !== 1'b0) @(posedge clk_sys);
      avs_write <= 1'b0;
      @(posedge clk_sys);
   endtask
   task automatic rd(input logic [6:0] ofs, input logic [31:0] exp);
      avs_address <= ofs[6:2];
      avs_read <= 1'b1;
      adr_q.push_back(ofs);
      exp_q.push_back(exp);
      @(posedge clk_sys);
      while (avs_waitrequest !== 1'b0) @(posedge clk_sys);
      avs_read <= 1'b0;
      @(posedge clk_sys);
   endtask
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 20000) begin
         errors++;
         tally_and_finish();
      end else if (avs_read === 1'b1 && avs_waitrequest === 1'b0) begin
         ofs_seen = adr_q.pop_front();
         exp_seen = exp_q.pop_front();
         check(ofs_seen, exp_seen, avs_readdata);
         // the output ports must agree with the register view of the same quantities
         case (ofs_seen)
            OFS_STATUS: check(ofs_seen, exp_seen & 32'h00000005,
               {29'h0, compensator_en, 1'b0, switched_out});
            OFS_ACT_INERTIA: check(ofs_seen, exp_seen, {16'h0000, inertia_ratio_out});
            OFS_ACT_POS: check(ofs_seen, exp_seen, {16'h0000, position_gain_out});
            OFS_ACT_SPEED: check(ofs_seen, exp_seen, {16'h0000, speed_gain_out});
            OFS_ACT_INTEG: check(ofs_seen, exp_seen, {16'h0000, speed_integral_out});
            default: begin
            end
         endcase
      end
   end
   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   initial begin
      void'($urandom(5));
      repeat (8) @(posedge clk_sys);
      rst_n <= 1'b1;
      @(posedge clk_sys);
      for (int i = 0; i < 12; i++) rd(7'(i * 4), rst_tab[i]);
      rd(7'h7C, 32'h0);
      code <= 4'h1;
      hit <= 1'b1;
      wr(OFS_TRIGGER, 32'h1);
      for (int m = 2; m < 4; m++) begin
         wr(OFS_TUNING_MODE, 32'(m));
         repeat (6) @(posedge clk_sys);
         rd(OFS_ACT_POS, 32'h2D);
         // condition holds on the pin, yet automatic modes must not switch
         rd(OFS_STATUS, 32'h2);
      end
      wr(OFS_TRIGGER, 32'h9);
      rd(OFS_TRIGGER, 32'h1);
      wr(OFS_POS_BASE, 32'h7D0);
      rd(OFS_POS_BASE, 32'h400);
      wr(OFS_THRESHOLD, 32'h500000);
      rd(OFS_THRESHOLD, 32'h3D0900);
      wr(OFS_INERTIA_ALT, 32'h514);
      rd(OFS_INERTIA_ALT, 32'h4B0);
      wr(OFS_SPEED_SCALE, 32'h5);
      rd(OFS_SPEED_SCALE, 32'hA);
      wr(OFS_TIME_CONST, 32'h7D0);
      rd(OFS_TIME_CONST, 32'h3E8);
      pb = 4 + $urandom % 1021;
      sb = 40 + $urandom % 8961;
      ib = 1 + $urandom % 1000;
      ps = 10 + $urandom % 491;
      ss = 10 + $urandom % 491;
      is2 = 10 + $urandom % 491;
      thr = 1 + $urandom % 3999999;
      wr(OFS_POS_BASE, pb);
      wr(OFS_SPEED_BASE, sb);
      wr(OFS_INTEG_BASE, ib);
      wr(OFS_POS_SCALE, ps);
      wr(OFS_SPEED_SCALE, ss);
      wr(OFS_INTEG_SCALE, is2);
      wr(OFS_THRESHOLD, thr);
      wr(OFS_INERTIA_BASE, 32'hA);
      wr(OFS_INERTIA_ALT, 32'h14);
      wr(OFS_TIME_CONST, 32'h0);
      wr(OFS_TUNING_MODE, 32'h0);
      for (int c = 1; c < 9; c++) begin
         code <= 4'(c);
         hit <= 1'b1;
         wr(OFS_TRIGGER, 32'(c));
         repeat (6) @(posedge clk_sys);
         rd(OFS_STATUS, 32'h3);
         rd(OFS_ACT_INERTIA, 32'h14);
         rd(OFS_ACT_POS, pb * ps / 100);
         rd(OFS_ACT_SPEED, sb * ss / 100);
         rd(OFS_ACT_INTEG, ib * is2 / 100);
         hit <= 1'b0;
         repeat (6) @(posedge clk_sys);
         rd(OFS_STATUS, 32'h0);
         rd(OFS_ACT_POS, pb);
         rd(OFS_ACT_INERTIA, 32'hA);
      end
      code <= 4'h0;
      hit <= 1'b1;
      wr(OFS_TRIGGER, 32'h0);
      repeat (6) @(posedge clk_sys);
      rd(OFS_STATUS, 32'h0);
      code <= 4'h4;
      wr(OFS_TRIGGER, 32'h4);
      wr(OFS_TUNING_MODE, 32'h1);
      repeat (6) @(posedge clk_sys);
      rd(OFS_STATUS, 32'h7);
      wr(OFS_TIME_CONST, 32'h8);
      hit <= 1'b0;
      repeat (2000) @(posedge clk_sys);
      rd(OFS_ACT_SPEED, sb);
      hit <= 1'b1;
      repeat (2000) @(posedge clk_sys);
      rd(OFS_ACT_SPEED, sb * ss / 100);
      tally_and_finish();
   end
endmodule
